/* File: mbad_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

module mbad_decoder (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    // Firmware level strap
    input  wire logic               fw_late,
    // Request header
    input  wire logic               req_valid,
    input  wire mbad_pkg::mbad_req_s req,
    // Decoded result
    output logic                    res_valid,
    output mbad_pkg::mbad_res_s     res
);

    ////////////////////////////////////////////////////////////////////////
    // Range matching, one matcher per map entry
    logic [mbad_pkg::ENT_NUM-1:0] ent_hit;
    logic [mbad_pkg::ENT_NUM-1:0] ent_fit;
    logic [15:0]                  ent_idx [mbad_pkg::ENT_NUM];

    genvar g;
    generate
        for (g = 0; g < mbad_pkg::ENT_NUM; g = g + 1)
        begin : g_ent
            mbad_range #(
                .LO   (mbad_pkg::ENT_LO[g]),
                .CNT  (mbad_pkg::ENT_CNT[g]),
                .BASE (mbad_pkg::ENT_BASE[g])
            ) u_range (
                .addr  (req.addr),
                .qty   (req.qty),
                .hit   (ent_hit[g]),
                .fits  (ent_fit[g]),
                .index (ent_idx[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Entry select; ranges are disjoint
    logic                   sel_hit;
    logic [3:0]             sel_ent;
    mbad_pkg::mbad_area_e   sel_area;
    logic                   sel_bit;
    logic                   sel_fit;
    logic [15:0]            sel_idx;

    always_comb
    begin
        sel_hit = 1'b0;
        sel_ent = 4'h0;
        for (int i = 0; i < mbad_pkg::ENT_NUM; i++)
        begin
            if (ent_hit[i] && !sel_hit)
            begin
                sel_hit = 1'b1;
                sel_ent = 4'(i);
            end
        end
    end

    assign sel_area = sel_hit ? mbad_pkg::ENT_AREA[sel_ent] : mbad_pkg::AREA_NONE;
    assign sel_bit  = mbad_pkg::ENT_IS_BIT[sel_ent];
    assign sel_fit  = ent_fit[sel_ent];
    assign sel_idx  = ent_idx[sel_ent];

    ////////////////////////////////////////////////////////////////////////
    // Function code against target area
    logic is_input;
    logic is_fast;
    logic fn_known;
    logic fn_area_ok;
    logic fn_write;

    assign is_input = sel_area == mbad_pkg::AREA_INPUT;
    assign is_fast  = sel_area == mbad_pkg::AREA_FAST_COUNTER;

    always_comb
    begin
        fn_known   = 1'b1;
        fn_area_ok = 1'b0;
        fn_write   = 1'b0;
        case (req.func)
            mbad_pkg::FC_RD_COIL,
            mbad_pkg::FC_RD_DISC:
                fn_area_ok = sel_bit;
            mbad_pkg::FC_RD_HOLD:
                fn_area_ok = !sel_bit;
            mbad_pkg::FC_RD_INP:
                fn_area_ok = sel_ent == mbad_pkg::ENT_X_WORD;
            mbad_pkg::FC_WR_COIL,
            mbad_pkg::FC_WR_COILS:
            begin
                fn_area_ok = sel_bit && !is_input;
                fn_write   = 1'b1;
            end
            mbad_pkg::FC_WR_REG,
            mbad_pkg::FC_WR_REGS,
            mbad_pkg::FC_RW_REGS:
            begin
                fn_area_ok = !sel_bit && !is_input;
                fn_write   = 1'b1;
            end
            default:
                fn_known = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Quantity limits
    logic qty_ok;

    mbad_qty u_qty (
        .func    (req.func),
        .qty     (req.qty),
        .is_fast (is_fast),
        .fw_late (fw_late),
        .qty_ok  (qty_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict; an error never names an area
    logic                 dec_err;
    mbad_pkg::mbad_res_s  res_nxt;

    assign dec_err = !sel_hit || !fn_known || !fn_area_ok || !qty_ok || !sel_fit;

    always_comb
    begin
        res_nxt.err      = dec_err;
        res_nxt.is_write = fn_write;
        res_nxt.is_bit   = sel_bit;
        res_nxt.area     = sel_area;
        res_nxt.index    = sel_idx;
        if (dec_err)
        begin
            res_nxt.is_write = 1'b0;
            res_nxt.is_bit   = 1'b0;
            res_nxt.area     = mbad_pkg::AREA_NONE;
            res_nxt.index    = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers
    mbad_pkg::mbad_res_s res_r;
    logic                res_valid_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            res_valid_r <= 1'b0;
        end
        else if (clk_en)
        begin
            res_valid_r <= req_valid;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            res_r <= '0;
        end
        else if (clk_en && req_valid)
        begin
            res_r <= res_nxt;
        end
    end

    assign res_valid = res_valid_r;
    assign res       = res_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_take(logic [7:0] f, logic [18:0] a, logic [15:0] q);
        clk_en && req_valid && req.func == f && req.addr == a && req.qty == q;
    endsequence

    sequence s_good(mbad_pkg::mbad_area_e ar, logic [15:0] ix);
        res_valid && !res.err && res.area == ar && res.index == ix;
    endsequence

    sequence s_bad;
        res_valid && res.err && res.area == mbad_pkg::AREA_NONE;
    endsequence

    chk_reset_clear: assert property (disable iff (1'b0)
        sys_rst |=> !res_valid && res == '0)
        else $error("Result not cleared by reset");

    chk_one_clock: assert property (
        clk_en && req_valid |=> res_valid)
        else $error("Result not presented one clock after request");

    chk_hold_frozen: assert property (
        !clk_en |=> $stable(res_valid) && $stable(res))
        else $error("State moved while clock enable low");

    chk_input_bits: assert property (
        s_take(mbad_pkg::FC_RD_DISC, 19'd125600, 16'd1)
        |=> s_good(mbad_pkg::AREA_INPUT, 16'h63FF))
        else $error("Input bit map wrong");

    chk_input_words: assert property (
        s_take(mbad_pkg::FC_RD_INP, 19'd332769, 16'd64)
        |=> s_good(mbad_pkg::AREA_INPUT, 16'h8000))
        else $error("Input word map wrong");

    chk_output_bits: assert property (
        s_take(mbad_pkg::FC_WR_COIL, 19'd041984, 16'd1)
        |=> s_good(mbad_pkg::AREA_OUTPUT, 16'hA3FF) ##0 res.is_write)
        else $error("Output bit map wrong");

    chk_output_words: assert property (
        s_take(mbad_pkg::FC_RD_HOLD, 19'd441024, 16'd1)
        |=> s_good(mbad_pkg::AREA_OUTPUT, 16'hA03F))
        else $error("Output word map wrong");

    chk_data_words: assert property (
        s_take(mbad_pkg::FC_RW_REGS, 19'd430000, 16'd1)
        |=> s_good(mbad_pkg::AREA_DATA, 16'h752F))
        else $error("Data word map wrong");

    chk_index_end: assert property (
        s_take(mbad_pkg::FC_WR_REG, 19'd465034, 16'd1)
        |=> s_good(mbad_pkg::AREA_INDEX, 16'hFE09))
        else $error("Index register map wrong");

    chk_bit_early: assert property (
        s_take(mbad_pkg::FC_RD_DISC, 19'd000001, 16'd257) ##0 !fw_late |=> s_bad)
        else $error("Early bit limit not enforced");

    chk_fast_limit: assert property (
        s_take(mbad_pkg::FC_RD_HOLD, 19'd464513, 16'd51) |=> s_bad)
        else $error("Fast counter word limit not enforced");

    chk_rd_inp_area: assert property (
        clk_en && req_valid && req.func == mbad_pkg::FC_RD_INP
        |=> res.err || res.area == mbad_pkg::AREA_INPUT)
        else $error("Code 04 reached a non-input area");

    chk_no_input_wr: assert property (
        clk_en && req_valid && fn_write |=> res.area != mbad_pkg::AREA_INPUT)
        else $error("Write reached the input area");

    chk_single_only: assert property (
        clk_en && req_valid && req.qty != 16'd1
        && (req.func == mbad_pkg::FC_WR_COIL || req.func == mbad_pkg::FC_WR_REG) |=> s_bad)
        else $error("Single write with count above one");

    chk_bit_late: assert property (
        s_take(mbad_pkg::FC_WR_COILS, 19'd000001, 16'd1600) ##0 fw_late
        |=> s_good(mbad_pkg::AREA_AUX, 16'h0000))
        else $error("Late bit limit refused a legal request");

    chk_multi_words: assert property (
        clk_en && req_valid && req.qty > 16'd100
        && (req.func == mbad_pkg::FC_WR_REGS || req.func == mbad_pkg::FC_RW_REGS) |=> s_bad)
        else $error("Multi-register count above limit");

    chk_err_quiet: assert property (
        res_valid && res.err |-> res.area == mbad_pkg::AREA_NONE && !res.is_write)
        else $error("Error result names an area");

endmodule : mbad_decoder

`default_nettype wire

/* File: mbad_pkg.sv */
package mbad_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Device areas reached through the Modbus address space
    typedef enum logic [3:0] {
        AREA_NONE,
        AREA_INPUT,
        AREA_OUTPUT,
        AREA_AUX,
        AREA_SPECIAL_RELAY,
        AREA_SPECIAL_DATA,
        AREA_DATA,
        AREA_STEP,
        AREA_TIMER,
        AREA_COUNTER,
        AREA_FAST_COUNTER,
        AREA_INDEX
    } mbad_area_e;

    ////////////////////////////////////////////////////////////////////////
    // Function codes
    localparam logic [7:0] FC_RD_COIL  = 8'h01;
    localparam logic [7:0] FC_RD_DISC  = 8'h02;
    localparam logic [7:0] FC_RD_HOLD  = 8'h03;
    localparam logic [7:0] FC_RD_INP   = 8'h04;
    localparam logic [7:0] FC_WR_COIL  = 8'h05;
    localparam logic [7:0] FC_WR_REG   = 8'h06;
    localparam logic [7:0] FC_WR_COILS = 8'h0F;
    localparam logic [7:0] FC_WR_REGS  = 8'h10;
    localparam logic [7:0] FC_RW_REGS  = 8'h17;

    ////////////////////////////////////////////////////////////////////////
    // Quantity limits
    localparam logic [15:0] QTY_BITS_EARLY = 16'd256;
    localparam logic [15:0] QTY_BITS_LATE  = 16'd1600;
    localparam logic [15:0] QTY_WORDS      = 16'd100;
    localparam logic [15:0] QTY_WORDS_FAST = 16'd50;
    localparam logic [15:0] QTY_SINGLE     = 16'd1;

    ////////////////////////////////////////////////////////////////////////
    // Address map, one entry per Modbus address range
    localparam int          ENT_NUM    = 16;
    localparam logic [3:0]  ENT_X_WORD = 4'h1;
    localparam logic [15:0] ENT_IS_BIT = 16'h2B35;
    localparam logic [18:0] ENT_LO [ENT_NUM] = '{
        19'd124577, 19'd332769, 19'd040961, 19'd440961,
        19'd000001, 19'd016385, 19'd449153, 19'd400001,
        19'd020481, 19'd057345, 19'd457345, 19'd061441,
        19'd461441, 19'd064513, 19'd464513, 19'd465025};
    localparam logic [18:0] ENT_CNT [ENT_NUM] = '{
        19'd1024, 19'd64,   19'd1024, 19'd64,
        19'd8192, 19'd4096, 19'd2048, 19'd30000,
        19'd2048, 19'd512,  19'd512,  19'd512,
        19'd512,  19'd256,  19'd256,  19'd10};
    localparam logic [15:0] ENT_BASE [ENT_NUM] = '{
        16'h6000, 16'h8000, 16'hA000, 16'hA000,
        16'h0000, 16'h4000, 16'hC000, 16'h0000,
        16'h5000, 16'hE000, 16'hE000, 16'hF000,
        16'hF000, 16'hFC00, 16'hFC00, 16'hFE00};
    localparam mbad_area_e ENT_AREA [ENT_NUM] = '{
        AREA_INPUT, AREA_INPUT, AREA_OUTPUT, AREA_OUTPUT,
        AREA_AUX, AREA_SPECIAL_RELAY, AREA_SPECIAL_DATA, AREA_DATA,
        AREA_STEP, AREA_TIMER, AREA_TIMER, AREA_COUNTER,
        AREA_COUNTER, AREA_FAST_COUNTER, AREA_FAST_COUNTER, AREA_INDEX};

    ////////////////////////////////////////////////////////////////////////
    // Request header and decoded result
    typedef struct packed {
        logic [7:0]  func;
        logic [18:0] addr;
        logic [15:0] qty;
    } mbad_req_s;

    typedef struct packed {
        mbad_area_e  area;
        logic [15:0] index;
        logic        is_bit;
        logic        is_write;
        logic        err;
    } mbad_res_s;

endpackage : mbad_pkg

/* File: mbad_range.sv */
`timescale 1ns/1ps
`default_nettype none

module mbad_range #(
    parameter logic [18:0] LO   = 19'd1,
    parameter logic [18:0] CNT  = 19'd1,
    parameter logic [15:0] BASE = 16'h0000
) (
    // Request
    input  wire logic [18:0] addr,
    input  wire logic [15:0] qty,
    // Match
    output logic             hit,
    output logic             fits,
    output logic [15:0]      index
);

    logic [19:0] offset;
    logic [19:0] span_end;

    assign offset   = {1'b0, addr} - {1'b0, LO};
    assign span_end = offset + {4'h0, qty};
    assign hit      = (addr >= LO) && (offset < {1'b0, CNT});
    assign fits     = span_end <= {1'b0, CNT};
    assign index    = BASE + offset[15:0];

endmodule : mbad_range

`default_nettype wire

/* File: mbad_qty.sv */
`timescale 1ns/1ps
`default_nettype none

module mbad_qty (
    // Request
    input  wire logic [7:0]  func,
    input  wire logic [15:0] qty,
    input  wire logic        is_fast,
    input  wire logic        fw_late,
    // Verdict
    output logic             qty_ok
);

    logic [15:0] limit;

    always_comb
    begin
        case (func)
            mbad_pkg::FC_RD_COIL,
            mbad_pkg::FC_RD_DISC,
            mbad_pkg::FC_WR_COILS:
                limit = fw_late ? mbad_pkg::QTY_BITS_LATE : mbad_pkg::QTY_BITS_EARLY;
            mbad_pkg::FC_RD_HOLD,
            mbad_pkg::FC_RD_INP,
            mbad_pkg::FC_WR_REGS,
            mbad_pkg::FC_RW_REGS:
                limit = is_fast ? mbad_pkg::QTY_WORDS_FAST : mbad_pkg::QTY_WORDS;
            mbad_pkg::FC_WR_COIL,
            mbad_pkg::FC_WR_REG:
                limit = mbad_pkg::QTY_SINGLE;
            default:
                limit = 16'h0000;
        endcase
    end

    assign qty_ok = (qty != 16'h0000) && (qty <= limit);

endmodule : mbad_qty

`default_nettype wire

/* File: mbad_master.sv */
`timescale 1ns/1ps
`default_nettype none

module mbad_master (
    // Clock
    input  wire logic                clk,
    // Request header
    output logic                     req_valid,
    output mbad_pkg::mbad_req_s      req,
    // Decoded result
    input  wire logic                res_valid,
    input  wire mbad_pkg::mbad_res_s res
);

    initial
    begin
        req_valid = 1'b0;
        req       = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One header per call, held one cycle, result taken a cycle later
    task automatic send(input logic [7:0] f, input logic [18:0] a, input logic [15:0] q,
                        output logic v, output mbad_pkg::mbad_res_s r);
        @(negedge clk);
        req_valid = 1'b1;
        req       = '{func: f, addr: a, qty: q};
        @(negedge clk);
        v         = res_valid;
        r         = res;
        req_valid = 1'b0;
        // Released header shows no stale value
        req       = ~req;
    endtask : send

endmodule : mbad_master

`default_nettype wire

/* File: mbad_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module mbad_decoder_tb;

    logic                clk;
    logic                sys_rst;
    logic                clk_en;
    logic                fw_late;
    logic                req_valid;
    mbad_pkg::mbad_req_s req;
    logic                res_valid;
    mbad_pkg::mbad_res_s res;
    int                  n_errors;
    int                  check_count;
    int                  cycles;

    mbad_decoder i_mbad_decoder (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .fw_late   (fw_late),
        .req_valid (req_valid),
        .req       (req),
        .res_valid (res_valid),
        .res       (res)
    );

    mbad_master i_mbad_master (
        .clk       (clk),
        .req_valid (req_valid),
        .req       (req),
        .res_valid (res_valid),
        .res       (res)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic run(input logic [7:0] f, input logic [18:0] a, input logic [15:0] q,
                       input logic ev, input mbad_pkg::mbad_res_s e);
        logic                v;
        mbad_pkg::mbad_res_s r;
        i_mbad_master.send(f, a, q, v, r);
        `CHK(v, ev)
        `CHK(r, e)
    endtask : run

    task automatic ok(input logic [7:0] f, input logic [18:0] a, input logic [15:0] q,
                      input mbad_pkg::mbad_area_e ar, input logic [15:0] ix, input logic b, input logic w);
        run(f, a, q, 1'b1, '{area: ar, index: ix, is_bit: b, is_write: w, err: 1'b0});
    endtask : ok

    task automatic bad(input logic [7:0] f, input logic [18:0] a, input logic [15:0] q);
        run(f, a, q, 1'b1, '{area: mbad_pkg::AREA_NONE, index: 16'h0000, is_bit: 1'b0,
                             is_write: 1'b0, err: 1'b1});
    endtask : bad

    ////////////////////////////////////////////////////////////////////////
    // Both ends of the input, output, aux, timer and fast counter areas, one end of the rest, one request every other cycle
    task automatic t_map();
        ok(8'h01, 19'd124577, 16'h0001, mbad_pkg::AREA_INPUT, 16'h6000, 1'b1, 1'b0);
        ok(8'h02, 19'd125600, 16'h0001, mbad_pkg::AREA_INPUT, 16'h63FF, 1'b1, 1'b0);
        ok(8'h04, 19'd332769, 16'h0001, mbad_pkg::AREA_INPUT, 16'h8000, 1'b0, 1'b0);
        ok(8'h03, 19'd332832, 16'h0001, mbad_pkg::AREA_INPUT, 16'h803F, 1'b0, 1'b0);
        ok(8'h0F, 19'd040961, 16'h0001, mbad_pkg::AREA_OUTPUT, 16'hA000, 1'b1, 1'b1);
        ok(8'h05, 19'd041984, 16'h0001, mbad_pkg::AREA_OUTPUT, 16'hA3FF, 1'b1, 1'b1);
        ok(8'h06, 19'd440961, 16'h0001, mbad_pkg::AREA_OUTPUT, 16'hA000, 1'b0, 1'b1);
        ok(8'h03, 19'd441024, 16'h0001, mbad_pkg::AREA_OUTPUT, 16'hA03F, 1'b0, 1'b0);
        ok(8'h05, 19'd000001, 16'h0001, mbad_pkg::AREA_AUX, 16'h0000, 1'b1, 1'b1);
        ok(8'h01, 19'd008192, 16'h0001, mbad_pkg::AREA_AUX, 16'h1FFF, 1'b1, 1'b0);
        ok(8'h0F, 19'd020480, 16'h0001, mbad_pkg::AREA_SPECIAL_RELAY, 16'h4FFF, 1'b1, 1'b1);
        ok(8'h10, 19'd449153, 16'h0001, mbad_pkg::AREA_SPECIAL_DATA, 16'hC000, 1'b0, 1'b1);
        ok(8'h17, 19'd430000, 16'h0001, mbad_pkg::AREA_DATA, 16'h752F, 1'b0, 1'b1);
        ok(8'h02, 19'd020481, 16'h0001, mbad_pkg::AREA_STEP, 16'h5000, 1'b1, 1'b0);
        ok(8'h01, 19'd057345, 16'h0001, mbad_pkg::AREA_TIMER, 16'hE000, 1'b1, 1'b0);
        ok(8'h03, 19'd457856, 16'h0001, mbad_pkg::AREA_TIMER, 16'hE1FF, 1'b0, 1'b0);
        ok(8'h06, 19'd461952, 16'h0001, mbad_pkg::AREA_COUNTER, 16'hF1FF, 1'b0, 1'b1);
        ok(8'h01, 19'd064513, 16'h0001, mbad_pkg::AREA_FAST_COUNTER, 16'hFC00, 1'b1, 1'b0);
        ok(8'h03, 19'd464768, 16'h0001, mbad_pkg::AREA_FAST_COUNTER, 16'hFCFF, 1'b0, 1'b0);
        ok(8'h06, 19'd465034, 16'h0001, mbad_pkg::AREA_INDEX, 16'hFE09, 1'b0, 1'b1);
        $display("test map done");
    endtask : t_map

    ////////////////////////////////////////////////////////////////////////
    // Codes against areas and unmapped addresses
    task automatic t_code();
        bad(8'h07, 19'd400001, 16'h0001);
        bad(8'h03, 19'd430001, 16'h0001);
        bad(8'h01, 19'd008193, 16'h0001);
        bad(8'h01, 19'd400001, 16'h0001);
        bad(8'h03, 19'd000001, 16'h0001);
        bad(8'h04, 19'd400001, 16'h0001);
        bad(8'h05, 19'd124577, 16'h0001);
        bad(8'h0F, 19'd125600, 16'h0001);
        bad(8'h06, 19'd332769, 16'h0001);
        bad(8'h10, 19'd332832, 16'h0001);
        $display("test code done");
    endtask : t_code

    ////////////////////////////////////////////////////////////////////////
    // Quantity limits at both firmware levels
    task automatic t_qty();
        fw_late = 1'b0;
        ok(8'h01, 19'd000001, 16'h0100, mbad_pkg::AREA_AUX, 16'h0000, 1'b1, 1'b0);
        bad(8'h02, 19'd000001, 16'h0101);
        bad(8'h0F, 19'd000001, 16'h0101);
        bad(8'h01, 19'd000001, 16'h0000);
        fw_late = 1'b1;
        ok(8'h0F, 19'd000001, 16'h0640, mbad_pkg::AREA_AUX, 16'h0000, 1'b1, 1'b1);
        bad(8'h01, 19'd000001, 16'h0641);
        ok(8'h03, 19'd400001, 16'h0064, mbad_pkg::AREA_DATA, 16'h0000, 1'b0, 1'b0);
        bad(8'h03, 19'd400001, 16'h0065);
        ok(8'h03, 19'd464513, 16'h0032, mbad_pkg::AREA_FAST_COUNTER, 16'hFC00, 1'b0, 1'b0);
        bad(8'h03, 19'd464513, 16'h0033);
        ok(8'h04, 19'd332769, 16'h0040, mbad_pkg::AREA_INPUT, 16'h8000, 1'b0, 1'b0);
        bad(8'h10, 19'd464513, 16'h0033);
        bad(8'h17, 19'd400001, 16'h0065);
        bad(8'h04, 19'd332769, 16'h0065);
        bad(8'h05, 19'd000001, 16'h0002);
        bad(8'h06, 19'd400001, 16'h0002);
        $display("test qty done");
    endtask : t_qty

    ////////////////////////////////////////////////////////////////////////
    // Result timing, clock enable hold, reset clear
    task automatic t_timing();
        mbad_pkg::mbad_res_s e;
        e = '{area: mbad_pkg::AREA_DATA, index: 16'h0000, is_bit: 1'b0, is_write: 1'b0, err: 1'b0};
        run(8'h03, 19'd400001, 16'h0001, 1'b1, e);
        @(negedge clk);
        `CHK(res_valid, 1'b0)
        `CHK(res, e)
        clk_en = 1'b0;
        run(8'h01, 19'd000001, 16'h0001, 1'b0, e);
        clk_en  = 1'b1;
        sys_rst = 1'b1;
        @(negedge clk);
        `CHK(res_valid, 1'b0)
        `CHK(res, 23'h00_0000)
        sys_rst = 1'b0;
        ok(8'h03, 19'd400001, 16'h0001, mbad_pkg::AREA_DATA, 16'h0000, 1'b0, 1'b0);
        $display("test timing done");
    endtask : t_timing

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_errors    = 0;
        check_count = 0;
        cycles      = 0;
        sys_rst     = 1'b1;
        clk_en      = 1'b1;
        fw_late     = 1'b0;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        t_map();
        t_code();
        t_qty();
        t_timing();
        report_and_stop();
    end

endmodule : mbad_decoder_tb

`default_nettype wire
